// ===== core/sfcr_defs.svh
// constants of the serial flash continuous read front end
// How it works
// (R01) program whole pages; erase at four granularities; not served here, only the three read opcodes are
// (R02) instruction starts on chip select falling edge
// (R03) every byte travels most significant bit first
// (R04) 264 mode: 11-bit page, 9-bit offset
// (R05) 256 mode: bits 18..8 page, 7..0 offset
// (R06) works in clock mode 0 and 3
// (R07) legacy read: opcode, three address, four dummies
// (R08) 264 mode start page and byte split
// (R09) 256 mode start page and byte split
// (R10) address counter advances by itself
// (R11) page end rolls into next page seamlessly
// (R12) array end wraps to first page seamlessly
// (R13) host holds select low whole transaction
// (R14) select rising ends read, output floats
// (R15) reads bypass buffers, leave them untouched
// (R16) fast read: opcode, three address, one dummy
// (R17) slow read: opcode, three address, no dummy
// (R18) sample on clock rise, shift on fall
// (R19) dummy byte contents ignored, only counted
`ifndef SFCR_DEFS_SVH
`define SFCR_DEFS_SVH

// ---------------------------------------------------------------
// opcodes and dummy bit counts
// ---------------------------------------------------------------
`define SFCR_OP_LEGACY 8'hE8
`define SFCR_OP_FAST 8'h0B
`define SFCR_OP_SLOW 8'h03
`define SFCR_DUMMY_LEGACY 6'h20
`define SFCR_DUMMY_FAST 6'h08
`define SFCR_DUMMY_SLOW 6'h00

// ---------------------------------------------------------------
// bit counts of the command phases
// ---------------------------------------------------------------
`define SFCR_OPC_LAST 5'h07
`define SFCR_ADR_LAST 5'h17
`define SFCR_BIT_LAST 3'h7
`define SFCR_BYTE_MSB 7
`define SFCR_ADDR_W 24

// ---------------------------------------------------------------
// address layouts
// ---------------------------------------------------------------
`define SFCR_P264_PAGE_HI 19
`define SFCR_P264_PAGE_LO 9
`define SFCR_P264_BYTE_HI 8
`define SFCR_P256_PAGE_HI 18
`define SFCR_P256_PAGE_LO 8
`define SFCR_P256_BYTE_HI 7
`define SFCR_LAST_BYTE_264 9'h107
`define SFCR_LAST_BYTE_256 9'h0FF
`define SFCR_IDLE_BYTE 8'hFF

// ---------------------------------------------------------------
// system clock
// ---------------------------------------------------------------
`define SFCR_CLK_PERIOD_NS 10

`endif

// ===== core/sfcr_pkg.sv
// types of the serial flash continuous read front end
package sfcr_pkg;
  // page and byte of a main array location
  typedef struct packed {
    logic [10:0] page;
    logic [8:0] byte_off;
  } sfcr_addr_t;

  // command sequencer states, gray along idle-opcode-address-dummy-data
  typedef enum logic [2:0] {
    SFCR_IDLE = 3'h0,
    SFCR_OPC = 3'h1,
    SFCR_ADR = 3'h3,
    SFCR_DUM = 3'h2,
    SFCR_DAT = 3'h6,
    SFCR_SKIP = 3'h7
  } sfcr_state_t;
endpackage

// ===== core/sfcr_top.sv
// serial command front end and continuous main array read path
`timescale 1ns/1ns
`include "sfcr_defs.svh"
module sfcr_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // serial pins from the host
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  // serial output pin, enable low while driving
  output logic so_out,
  output logic so_oe_n,
  // page size select, high for 256-byte pages
  input wire logic page_bin,
  // array read request
  output logic arr_req_valid,
  input wire logic arr_req_ready,
  output sfcr_pkg::sfcr_addr_t arr_req_addr,
  // array read answer
  input wire logic arr_rsp_valid,
  output logic arr_rsp_ready,
  input wire logic [7:0] arr_rsp_data
);
  import sfcr_pkg::*;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // split a received address into page and byte
  function automatic sfcr_addr_t addr_split(input logic [23:0] a, input logic bin);
    sfcr_addr_t r;
    if (bin) begin
      r.page = a[`SFCR_P256_PAGE_HI:`SFCR_P256_PAGE_LO]; // [R05] [R09]
      r.byte_off = {1'b0, a[`SFCR_P256_BYTE_HI:0]}; // [R05] [R09]
    end else begin
      r.page = a[`SFCR_P264_PAGE_HI:`SFCR_P264_PAGE_LO]; // [R04] [R08]
      r.byte_off = a[`SFCR_P264_BYTE_HI:0]; // [R04] [R08]
    end
    return r;
  endfunction

  // next sequential location, crossing pages and wrapping the array
  function automatic sfcr_addr_t addr_incr(input sfcr_addr_t a, input logic bin);
    sfcr_addr_t r;
    logic [8:0] last;
    last = bin ? `SFCR_LAST_BYTE_256 : `SFCR_LAST_BYTE_264;
    r = a;
    if (a.byte_off >= last) begin
      r.byte_off = '0; // [R11]
      r.page = a.page + 11'h001; // [R12] last page rolls to page zero
    end else begin
      r.byte_off = a.byte_off + 9'h001; // [R10]
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg; // chip select synchroniser
  logic sck_s1_reg, sck_s2_reg, sck_s3_reg; // serial clock synchroniser
  logic si_s1_reg, si_s2_reg; // serial input synchroniser
  sfcr_state_t st_reg, st_next; // sequencer state
  logic [23:0] sh_reg, sh_next; // input shift register
  logic [4:0] cnt_reg, cnt_next; // bits taken in current phase
  logic [5:0] dum_reg, dum_next; // dummy bits still to come
  logic bin_reg, bin_next; // page size caught at select
  sfcr_addr_t ptr_reg, ptr_next; // next array location to fetch
  logic req_v_reg, req_v_next; // request outstanding on port
  sfcr_addr_t req_a_reg, req_a_next; // request address
  logic pend_reg, pend_next; // answer awaited
  logic live_reg, live_next; // awaited answer belongs to this read
  logic [7:0] fifo_reg [2]; // two-entry data buffer
  logic [7:0] fifo_next [2];
  logic wp_reg, wp_next, rp_reg, rp_next; // buffer pointers
  logic [1:0] fcnt_reg, fcnt_next; // buffer fill level
  logic rdy_reg, rdy_next; // buffer has room
  logic [7:0] ob_reg, ob_next; // output byte shifter
  logic [2:0] obit_reg, obit_next; // bits left in output byte
  logic so_reg, so_next; // serial output level
  logic oen_reg, oen_next; // output enable, low drives

  // ---------------------------------------------------------------
  // edge detection on synchronised pins
  // ---------------------------------------------------------------
  logic cs_fall, cs_high, sck_rise, sck_fall, push, pop;
  // either idle clock level is fine: only edges matter
  assign sck_rise = sck_s2_reg & ~sck_s3_reg; // [R06] [R18]
  assign sck_fall = ~sck_s2_reg & sck_s3_reg; // [R06] [R18]
  assign cs_fall = ~cs_s2_reg & cs_s3_reg; // [R02]
  assign cs_high = cs_s2_reg;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [23:0] sh_in;
    logic [7:0] head;
    sh_in = '0;
    head = '0;
    st_next = st_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    dum_next = dum_reg;
    bin_next = bin_reg;
    ptr_next = ptr_reg;
    req_v_next = req_v_reg;
    req_a_next = req_a_reg;
    pend_next = pend_reg;
    live_next = live_reg;
    fifo_next = fifo_reg;
    wp_next = wp_reg;
    rp_next = rp_reg;
    fcnt_next = fcnt_reg;
    ob_next = ob_reg;
    obit_next = obit_reg;
    so_next = so_reg;
    oen_next = oen_reg;
    pop = 1'b0;
    // shift one bit in, first bit ends up on top
    sh_in = {sh_reg[22:0], si_s2_reg}; // [R03]
    unique case (st_reg)
      // wait for a new instruction
      SFCR_IDLE: begin
        if (cs_fall) begin
          st_next = SFCR_OPC; // [R02]
          cnt_next = '0;
          bin_next = page_bin;
        end
      end
      // take the opcode byte
      SFCR_OPC: begin
        if (sck_rise) begin
          sh_next = sh_in;
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == `SFCR_OPC_LAST) begin
            cnt_next = '0;
            st_next = SFCR_ADR;
            if (sh_in[7:0] == `SFCR_OP_LEGACY) begin
              dum_next = `SFCR_DUMMY_LEGACY; // [R07]
            end else if (sh_in[7:0] == `SFCR_OP_FAST) begin
              dum_next = `SFCR_DUMMY_FAST; // [R16]
            end else if (sh_in[7:0] == `SFCR_OP_SLOW) begin
              dum_next = `SFCR_DUMMY_SLOW; // [R17]
            end else begin
              st_next = SFCR_SKIP; // other commands are not served here
            end
          end
        end
      end
      // take three address bytes
      SFCR_ADR: begin
        if (sck_rise) begin
          sh_next = sh_in;
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == `SFCR_ADR_LAST) begin
            ptr_next = addr_split(sh_in, bin_reg);
            st_next = (dum_reg == '0) ? SFCR_DAT : SFCR_DUM; // [R17]
            oen_next = (dum_reg != '0); // [R17] drive right away
            obit_next = '0;
          end
        end
      end
      // count dummy clocks, contents dropped
      SFCR_DUM: begin
        if (sck_rise) begin
          dum_next = dum_reg - 6'h01; // [R19]
          if (dum_reg == 6'h01) begin
            st_next = SFCR_DAT; // [R07] [R16]
            oen_next = 1'b0;
          end
        end
      end
      // stream bytes out on falling clock edges
      SFCR_DAT: begin
        if (sck_fall) begin
          if (obit_reg == '0) begin
            head = (fcnt_reg == '0) ? `SFCR_IDLE_BYTE : fifo_reg[rp_reg];
            pop = (fcnt_reg != '0);
            so_next = head[`SFCR_BYTE_MSB]; // [R03] [R18]
            ob_next = {head[6:0], 1'b0};
            obit_next = `SFCR_BIT_LAST;
          end else begin
            so_next = ob_reg[`SFCR_BYTE_MSB]; // [R03] [R18]
            ob_next = {ob_reg[6:0], 1'b0};
            obit_next = obit_reg - 3'h1;
          end
        end
      end
      // unsupported command: wait for deselect
      SFCR_SKIP: begin
        oen_next = 1'b1;
      end
      default: begin
        st_next = SFCR_IDLE;
      end
    endcase
    // array fetch ahead of the shifter, array port is read only
    if (req_v_reg && arr_req_ready) begin
      req_v_next = 1'b0;
      pend_next = 1'b1;
    end
    if ((st_reg == SFCR_DUM || st_reg == SFCR_DAT) && !req_v_reg && !pend_reg
        && fcnt_reg != 2'h2 && !cs_high) begin
      req_v_next = 1'b1; // [R01] [R15] array only, no buffer access
      req_a_next = ptr_reg;
      ptr_next = addr_incr(ptr_reg, bin_reg); // [R10] [R11] [R12]
      live_next = 1'b1;
    end
    if (arr_rsp_valid && rdy_reg) begin
      pend_next = 1'b0;
      live_next = 1'b0;
    end
    // buffer bookkeeping
    if (push) begin
      fifo_next[wp_reg] = arr_rsp_data;
      wp_next = ~wp_reg;
    end
    if (pop) begin
      rp_next = ~rp_reg;
    end
    fcnt_next = fcnt_reg + {1'b0, push} - {1'b0, pop};
    // deselect ends the read, empties the buffer and floats the output
    if (cs_high) begin
      st_next = SFCR_IDLE; // [R13] [R14]
      oen_next = 1'b1; // [R14]
      live_next = 1'b0;
      wp_next = 1'b0;
      rp_next = 1'b0;
      fcnt_next = '0;
    end
    rdy_next = (fcnt_next != 2'h2);
  end
  assign push = arr_rsp_valid & rdy_reg & live_reg & ~cs_high;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_s3_reg <= 1'b0;
      si_s1_reg <= 1'b0;
      si_s2_reg <= 1'b0;
      st_reg <= SFCR_IDLE;
      sh_reg <= '0;
      cnt_reg <= '0;
      dum_reg <= '0;
      bin_reg <= 1'b0;
      ptr_reg <= '0;
      req_v_reg <= 1'b0;
      req_a_reg <= '0;
      pend_reg <= 1'b0;
      live_reg <= 1'b0;
      fifo_reg[0] <= '0;
      fifo_reg[1] <= '0;
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      fcnt_reg <= '0;
      rdy_reg <= 1'b1;
      ob_reg <= '0;
      obit_reg <= '0;
      so_reg <= 1'b0;
      oen_reg <= 1'b1;
    end else begin
      cs_s1_reg <= cs_n_pin;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      sck_s1_reg <= sck_pin;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      si_s1_reg <= si_pin;
      si_s2_reg <= si_s1_reg;
      st_reg <= st_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      dum_reg <= dum_next;
      bin_reg <= bin_next;
      ptr_reg <= ptr_next;
      req_v_reg <= req_v_next;
      req_a_reg <= req_a_next;
      pend_reg <= pend_next;
      live_reg <= live_next;
      fifo_reg <= fifo_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      fcnt_reg <= fcnt_next;
      rdy_reg <= rdy_next;
      ob_reg <= ob_next;
      obit_reg <= obit_next;
      so_reg <= so_next;
      oen_reg <= oen_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs straight from flip-flops
  // ---------------------------------------------------------------
  assign so_out = so_reg;
  assign so_oe_n = oen_reg;
  assign arr_req_valid = req_v_reg;
  assign arr_req_addr = req_a_reg;
  assign arr_rsp_ready = rdy_reg;
endmodule

// ===== testbench/sfcr_array.sv
// behavioural main array answering one byte per request
`timescale 1ns/1ns
module sfcr_array (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // high for a slow array
  input wire logic slow,
  // request side
  input wire logic arr_req_valid,
  output logic arr_req_ready,
  input wire sfcr_pkg::sfcr_addr_t arr_req_addr,
  // answer side
  output logic arr_rsp_valid,
  input wire logic arr_rsp_ready,
  output logic [7:0] arr_rsp_data
);
  import sfcr_pkg::*;
  logic busy_reg;
  logic tog_reg; // alternate-cycle refusal of a slow array
  logic [3:0] cnt_reg;
  sfcr_addr_t adr_reg;
  // one access at a time; a slow array also refuses every other cycle,
  // so requests must be held until accepted
  assign arr_req_ready = ~busy_reg & (~slow | tog_reg);
  // answer after a countdown, data computed from the latched address
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
      tog_reg <= 1'b0;
      cnt_reg <= 4'h0;
      adr_reg <= '0;
      arr_rsp_valid <= 1'b0;
      arr_rsp_data <= 8'h00;
    end else begin
      arr_rsp_valid <= 1'b0;
      tog_reg <= ~tog_reg;
      // data bus toggles between answers so no stale byte looks valid
      arr_rsp_data <= ~arr_rsp_data;
      if (arr_req_ready && arr_req_valid) begin
        busy_reg <= 1'b1;
        adr_reg <= arr_req_addr;
        cnt_reg <= slow ? 4'h6 : 4'h0;
      end else if (busy_reg && cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end else if (busy_reg && arr_rsp_ready) begin
        busy_reg <= 1'b0;
        arr_rsp_valid <= 1'b1;
        arr_rsp_data <= {adr_reg.page[3:0], 4'h0} ^ adr_reg.byte_off[7:0]
          ^ {7'h0, adr_reg.byte_off[8]};
      end
    end
  end
endmodule

// ===== testbench/sfcr_props.sv
// port assertions for the continuous read front end
`timescale 1ns/1ns
module sfcr_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // serial pins
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic so_out,
  input wire logic so_oe_n,
  // array port
  input wire logic arr_req_valid,
  input wire logic arr_req_ready,
  input wire sfcr_pkg::sfcr_addr_t arr_req_addr,
  input wire logic arr_rsp_valid,
  input wire logic arr_rsp_ready
);
  import sfcr_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // helper: age since the last sck fall, and one request in flight
  logic sck_reg, sck_next, out_reg, out_next;
  logic [3:0] age_reg, age_next;
  always_comb begin
    sck_next = sck_pin;
    age_next = (age_reg == 4'hF) ? age_reg : age_reg + 4'h1;
    out_next = out_reg;
    // a fall restarts the age
    if (sck_reg && !sck_pin) begin
      age_next = 4'h0;
    end
    if (arr_req_valid && arr_req_ready) begin
      out_next = 1'b1;
    end else if (arr_rsp_valid && arr_rsp_ready) begin
      out_next = 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sck_reg <= 1'b0;
      age_reg <= 4'hF;
      out_reg <= 1'b0;
    end else begin
      sck_reg <= sck_next;
      age_reg <= age_next;
      out_reg <= out_next;
    end
  end
  a_req_held: assert property (arr_req_valid && !arr_req_ready
    |=> arr_req_valid && $stable(arr_req_addr))
    else $error("request dropped or changed before acceptance");
  a_one_outstanding: assert property (out_reg |-> !arr_req_valid)
    else $error("second request while one is in flight");
  a_oe_idle: assert property (cs_n_pin [*6] |-> so_oe_n)
    else $error("output driven while deselected");
  a_so_on_fall: assert property (!so_oe_n && $past(so_oe_n) == 1'b0
    && $changed(so_out) |-> age_reg inside {[1:6]})
    else $error("output bit changed away from a clock fall");
  a_opcode_quiet: assert property ($fell(cs_n_pin) |-> so_oe_n [*8])
    else $error("output driven during opcode");
  a_no_early_req: assert property ($fell(cs_n_pin) |-> !arr_req_valid [*8])
    else $error("array request during opcode");
  a_reset_quiet: assert property ($rose(nrst)
    |-> so_oe_n && !arr_req_valid && arr_rsp_ready)
    else $error("outputs not idle after reset");
  a_oe_needs_cs: assert property ($fell(so_oe_n) |-> !cs_n_pin && !$past(cs_n_pin, 3))
    else $error("output enabled without selection");
endmodule
bind sfcr_top sfcr_props sfcr_props_inst (.clk_sys(clk_sys), .nrst(nrst), .cs_n_pin(cs_n_pin),
  .sck_pin(sck_pin), .so_out(so_out), .so_oe_n(so_oe_n), .arr_req_valid(arr_req_valid),
  .arr_req_ready(arr_req_ready), .arr_req_addr(arr_req_addr), .arr_rsp_valid(arr_rsp_valid),
  .arr_rsp_ready(arr_rsp_ready));

// ===== testbench/sfcr_top_tb.sv
// self-checking bench: host frames against the front end
`timescale 1ns/1ns
module sfcr_top_tb;
  import sfcr_pkg::*;
  localparam int H = 8; // clocks per serial clock half period
  logic clk_sys, nrst, cs_n_pin, sck_pin, si_pin, so_out, so_oe_n, page_bin, slow;
  logic arr_req_valid, arr_req_ready, arr_rsp_valid, arr_rsp_ready;
  logic [7:0] arr_rsp_data;
  sfcr_addr_t arr_req_addr;
  int n_fail, check_count;
  sfcr_top sfcr_top_inst (.clk_sys(clk_sys), .nrst(nrst), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
    .si_pin(si_pin), .so_out(so_out), .so_oe_n(so_oe_n), .page_bin(page_bin),
    .arr_req_valid(arr_req_valid), .arr_req_ready(arr_req_ready), .arr_req_addr(arr_req_addr),
    .arr_rsp_valid(arr_rsp_valid), .arr_rsp_ready(arr_rsp_ready), .arr_rsp_data(arr_rsp_data));
  sfcr_array sfcr_array_inst (.clk_sys(clk_sys), .nrst(nrst), .slow(slow),
    .arr_req_valid(arr_req_valid), .arr_req_ready(arr_req_ready), .arr_req_addr(arr_req_addr),
    .arr_rsp_valid(arr_rsp_valid), .arr_rsp_ready(arr_rsp_ready), .arr_rsp_data(arr_rsp_data));
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic test_done;
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // one serial clock: fall, sample output late in low half, rise
  task automatic xbit(input logic b, output logic o);
    sck_pin = 1'b0;
    si_pin = b;
    tick(H);
    // a floated pin reads as the inverse, so a missing drive shows up
    o = so_oe_n ? ~so_out : so_out;
    sck_pin = 1'b1;
    tick(H);
  endtask
  // stored byte at a location, as loaded into the array
  function automatic logic [7:0] dat(input sfcr_addr_t a);
    return {a.page[3:0], 4'h0} ^ a.byte_off[7:0] ^ {7'h0, a.byte_off[8]};
  endfunction
  // next location: last byte of a page rolls into the next page
  function automatic sfcr_addr_t nxt(input sfcr_addr_t a, input logic bin);
    sfcr_addr_t n;
    n = a;
    n.byte_off = a.byte_off + 9'h1;
    if (a.byte_off >= (bin ? 9'h0FF : 9'h107)) begin
      n.byte_off = 9'h000;
      n.page = a.page + 11'h001;
    end
    return n;
  endfunction
  // whole frame: opcode, address, dummies, bytes, abort mid byte
  task automatic frame(input logic m3, input logic bin, input logic [7:0] op,
                       input logic [23:0] adr, input int ndum, input logic [7:0] dum,
                       input int nbyte);
    sfcr_addr_t a;
    logic [7:0] got;
    logic o;
    logic ok;
    a = bin ? sfcr_addr_t'({adr[18:8], 1'b0, adr[7:0]}) : sfcr_addr_t'(adr[19:0]);
    ok = (op == 8'hE8) || (op == 8'h0B) || (op == 8'h03);
    got = 8'h00;
    page_bin = bin;
    sck_pin = m3;
    tick(2);
    cs_n_pin = 1'b0;
    tick(4);
    for (int i = 0; i < 32; i++) xbit((i < 8) ? op[7 - i] : adr[31 - i], o);
    for (int i = 0; i < ndum; i++) xbit(dum[7 - (i % 8)], o);
    // host stalls, both buffer entries fill
    tick(60);
    if (ndum == 32) chk("rsp_ready", 8'h00, {7'h0, arr_rsp_ready});
    for (int i = 0; i < nbyte * 8 + 3; i++) begin
      xbit(1'b0, o);
      got = {got[6:0], o};
      if (i % 8 == 7) begin
        chk("so_oe_n", {7'h0, !ok}, {7'h0, so_oe_n});
        if (ok) chk("so byte", dat(a), got);
        a = nxt(a, bin);
      end
    end
    sck_pin = m3;
    tick(1);
    cs_n_pin = 1'b1;
    tick(6);
    chk("so_oe_n idle", 8'h01, {7'h0, so_oe_n});
  endtask
  task automatic t_legacy;
    frame(1'b0, 1'b0, 8'hE8, 24'h000B06, 32, 8'hA5, 3);
  endtask
  task automatic t_fast;
    slow = 1'b1;
    frame(1'b1, 1'b1, 8'h0B, 24'h07FFFE, 8, 8'h00, 3);
    slow = 1'b0;
  endtask
  task automatic t_slow;
    frame(1'b0, 1'b0, 8'h03, 24'h0FFF07, 0, 8'h00, 2);
  endtask
  task automatic t_dummy;
    frame(1'b1, 1'b0, 8'hE8, 24'h000B06, 32, 8'h00, 1);
  endtask
  task automatic t_bad_op;
    frame(1'b0, 1'b0, 8'h5A, 24'h000000, 0, 8'h00, 1);
  endtask
  // cut a hang short
  initial begin
    tick(50000);
    n_fail++;
    test_done();
  end
  initial begin
    nrst = 1'b0;
    cs_n_pin = 1'b1;
    sck_pin = 1'b0;
    si_pin = 1'b0;
    page_bin = 1'b0;
    slow = 1'b0;
    n_fail = 0;
    check_count = 0;
    tick(20);
    nrst = 1'b1;
    tick(4);
    t_legacy();
    t_fast();
    t_slow();
    t_dummy();
    t_bad_op();
    test_done();
  end
endmodule
